// *** rtl/nmi_consts.svh ***
/*
  Timing counts, strap codes and field positions for the narrow memory pin control block.
  Assumes it is included by its bare name from the design file only; the package does not include it.
*/
`ifndef NMI_CONSTS_SVH
`define NMI_CONSTS_SVH

// Core clock rate in MHz.
`define NMI_CLK_MHZ       125
// Core cycles per half period of the CPU/4 and CPU/6 derived clocks.
`define NMI_DIV4_HALF     2'h2
`define NMI_DIV6_HALF     2'h3
// Strap codes on address pins 15:14; the remaining codes select the clock pin.
`define NMI_STRAP_DIV4    2'h1
`define NMI_STRAP_DIV6    2'h2
// Word address field that decodes the space selects (bits 31:26).
`define NMI_SPACE_HI      31
`define NMI_SPACE_LO      26
// Upper four decode bits that mark an external space access.
`define NMI_SPACE_BASE    4'h8
// Core cycles after reset release before the strap is taken.
`define NMI_STRAP_WAIT    2'h2

`endif

// *** rtl/nmi_pkg.sv ***
/*
  Types shared by the narrow memory pin control block.
  Assumes the constants header is on the include path.
*/
package nmi_pkg;

  // Memory type of one external space.
  typedef enum logic [1:0] {MEM_ASYNC, MEM_SDRAM, MEM_SYNC} nmi_mem_t;

  // Source of the interface input clock.
  typedef enum logic [1:0] {SRC_PIN, SRC_DIV4, SRC_DIV6} nmi_src_t;

  // Output clock divide ratio.
  typedef enum logic [1:0] {DIV_BY1, DIV_BY2, DIV_BY4} nmi_ratio_t;

  // Arbitration state.
  typedef enum logic {ARB_OWN, ARB_GRANT} nmi_arb_t;

  // Strobe intents from the access sequencer, active high.
  typedef struct packed {
    logic read;
    logic out_en;
    logic write;
    logic addr_stb;
    logic sd_cas;
    logic sd_ras;
    logic sd_we;
  } nmi_stb_t;

  // One access beat offered by the sequencer.
  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic        half;
    logic        byte0;
    logic        periph;
    logic [31:0] word_addr;
    nmi_stb_t    stb;
  } nmi_acc_t;

  // Driven pin levels, active-low strobes.
  typedef struct packed {
    logic [3:0] space_select_n;
    logic [1:0] byte_lane_select_n;
    logic       read_strobe_n;
    logic       output_strobe_n;
    logic       write_strobe_n;
    logic       peripheral_direct_transfer_n;
    logic       full_rate_clock_out;
    logic       divided_clock_out;
  } nmi_pins_t;

  // Whole state of the block.
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] hold_sync;
    logic [3:0] strap_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;
    nmi_src_t   src;
    logic       pin_prev;
    logic [1:0] div_cnt;
    logic [1:0] tick_cnt;
    nmi_arb_t   arb;
    nmi_pins_t  pins;
  } nmi_state_t;

endpackage : nmi_pkg

// *** rtl/nmi_pin_ctrl.sv ***
/*
  Pin control of the narrow external memory interface: clock source strap, two output
  clocks, space decode, byte lanes, shared strobes, direct peripheral transfer and host
  bus arbitration.
  Assumes a sequencer on clk offers one access beat per cycle and holds it while stalled;
  pins from outside (clock pin, hold request, straps) are asynchronous to clk.
*/
`include "nmi_consts.svh"

module nmi_pin_ctrl (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_n,
  // External pins sampled by the block.
  input  wire logic               iface_clock_in,
  input  wire logic [1:0]         iface_address_strap,
  input  wire logic               bus_hold_request,
  // Static configuration.
  input  wire nmi_pkg::nmi_mem_t  space_mem_type [4],
  input  wire logic               read_enable_select,
  input  wire logic               mem_is_8bit,
  input  wire nmi_pkg::nmi_ratio_t clk_ratio,
  // Access beats from the sequencer.
  input  wire nmi_pkg::nmi_acc_t  acc,
  output logic                    acc_ready,
  // Pins driven by the block.
  output nmi_pkg::nmi_pins_t      pins,
  output logic                    pins_oe,
  output logic                    bus_grant_ack_n,
  output logic                    bus_need_request,
  output nmi_pkg::nmi_src_t       clk_source
);

  // Registered and next state.
  nmi_pkg::nmi_state_t st_q;
  nmi_pkg::nmi_state_t st_d;
  // Half period tick of the selected input clock.
  logic                tick;
  // Decoded space of the offered beat.
  logic [3:0]          space_hit;
  // Memory type of the addressed space.
  nmi_pkg::nmi_mem_t   mtype;

  // One-hot decode of the space field, one select per space.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_space
      assign space_hit[gi] = acc.valid &&
        (acc.word_addr[`NMI_SPACE_HI:`NMI_SPACE_LO] == {`NMI_SPACE_BASE, 2'(gi)});
    end
  endgenerate

  // Picks the type of the addressed space; unmapped beats default to asynchronous.
  always_comb
  begin
    mtype = nmi_pkg::MEM_ASYNC;
    for (int i = 0; i < 4; i++)
    begin
      if (space_hit[i])
      begin
        mtype = space_mem_type[i];
      end
    end
  end

  // Next-state logic of the whole block.
  always_comb
  begin
    st_d = st_q;
    tick = 1'b0;
    // Two-flop synchronisers for every outside pin.
    st_d.pin_sync   = {st_q.pin_sync[0], iface_clock_in};
    st_d.hold_sync  = {st_q.hold_sync[0], bus_hold_request};
    st_d.strap_sync = {st_q.strap_sync[1:0], iface_address_strap};

    if (!st_q.strap_done)
    begin
      st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      if (st_q.strap_cnt == `NMI_STRAP_WAIT)
      begin
        st_d.strap_done = 1'b1;
        unique case (st_q.strap_sync[3:2])
          `NMI_STRAP_DIV4: st_d.src = nmi_pkg::SRC_DIV4;
          `NMI_STRAP_DIV6: st_d.src = nmi_pkg::SRC_DIV6;
          default:         st_d.src = nmi_pkg::SRC_PIN;
        endcase
      end
    end

    // Half period ticks from the chosen source.
    st_d.pin_prev = st_q.pin_sync[1];
    unique case (st_q.src)
      nmi_pkg::SRC_PIN:
      begin
        // Either edge of the synchronised pin.
        tick = st_q.pin_sync[1] ^ st_q.pin_prev;
      end
      default:
      begin
        // CPU/4 or CPU/6 divider from the core clock.
        if (st_q.div_cnt + 2'h1 >= ((st_q.src == nmi_pkg::SRC_DIV4) ?
            `NMI_DIV4_HALF : `NMI_DIV6_HALF))
        begin
          tick         = 1'b1;
          st_d.div_cnt = 2'h0;
        end
        else
        begin
          st_d.div_cnt = st_q.div_cnt + 2'h1;
        end
      end
    endcase

    if (tick && st_q.strap_done)
    begin
      st_d.pins.full_rate_clock_out = ~st_q.pins.full_rate_clock_out;
      st_d.tick_cnt = st_q.tick_cnt + 2'h1;
      unique case (clk_ratio)
        nmi_pkg::DIV_BY2: if (st_q.tick_cnt[0])
                          begin
                            st_d.pins.divided_clock_out = ~st_q.pins.divided_clock_out;
                          end
        nmi_pkg::DIV_BY4: if (st_q.tick_cnt == 2'h3)
                          begin
                            st_d.pins.divided_clock_out = ~st_q.pins.divided_clock_out;
                          end
        default:          st_d.pins.divided_clock_out = ~st_q.pins.divided_clock_out;
      endcase
    end

    // Idle pin levels unless a beat is taken this cycle.
    st_d.pins.space_select_n               = 4'hf;
    st_d.pins.byte_lane_select_n           = 2'h3;
    st_d.pins.read_strobe_n                = 1'b1;
    st_d.pins.output_strobe_n              = 1'b1;
    st_d.pins.write_strobe_n               = 1'b1;
    st_d.pins.peripheral_direct_transfer_n = 1'b1;

    unique case (st_q.arb)
      nmi_pkg::ARB_OWN:
      begin
        if (st_q.hold_sync[1] && !acc.valid)
        begin
          st_d.arb = nmi_pkg::ARB_GRANT;
        end
        else if (acc.valid)
        begin
          st_d.pins.space_select_n = ~space_hit;
          if (mem_is_8bit)
          begin
            st_d.pins.byte_lane_select_n = 2'h2;
          end
          else if (acc.half || !acc.is_write)
          begin
            st_d.pins.byte_lane_select_n = 2'h0;
          end
          else
          begin
            st_d.pins.byte_lane_select_n = acc.byte0 ? 2'h1 : 2'h2;
          end
          unique case (mtype)
            nmi_pkg::MEM_SDRAM:
            begin
              st_d.pins.read_strobe_n   = ~acc.stb.sd_cas;
              st_d.pins.output_strobe_n = ~acc.stb.sd_ras;
              st_d.pins.write_strobe_n  = ~acc.stb.sd_we;
            end
            nmi_pkg::MEM_SYNC:
            begin
              st_d.pins.read_strobe_n   = read_enable_select ? ~acc.stb.read
                                                             : ~acc.stb.addr_stb;
              st_d.pins.output_strobe_n = ~acc.stb.out_en;
              st_d.pins.write_strobe_n  = ~acc.stb.write;
            end
            default:
            begin
              // Asynchronous read, output and write enables.
              st_d.pins.read_strobe_n   = ~acc.stb.read;
              st_d.pins.output_strobe_n = ~acc.stb.out_en;
              st_d.pins.write_strobe_n  = ~acc.stb.write;
            end
          endcase
          st_d.pins.peripheral_direct_transfer_n = ~acc.periph;
        end
      end
      nmi_pkg::ARB_GRANT:
      begin
        if (!st_q.hold_sync[1])
        begin
          st_d.arb = nmi_pkg::ARB_OWN;
        end
      end
    endcase
  end

  // Registers the whole state; reset loads constants only.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q      <= '0;
      st_q.pins <= '{space_select_n: 4'hf, byte_lane_select_n: 2'h3, read_strobe_n: 1'b1,
                    output_strobe_n: 1'b1, write_strobe_n: 1'b1,
                    peripheral_direct_transfer_n: 1'b1, full_rate_clock_out: 1'b0,
                    divided_clock_out: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Beats stall only while the host owns the bus; a pending hold waits for the offered beat,
  // so a beat shown on the pins is always one the sequencer sees taken.
  assign acc_ready        = (st_q.arb == nmi_pkg::ARB_OWN);
  assign pins             = st_q.pins;
  assign pins_oe          = (st_q.arb == nmi_pkg::ARB_OWN);
  assign bus_grant_ack_n  = (st_q.arb != nmi_pkg::ARB_GRANT);
  // Tells the host the device has work waiting.
  assign bus_need_request = (st_q.arb == nmi_pkg::ARB_GRANT) && acc.valid;
  assign clk_source       = st_q.src;

endmodule : nmi_pin_ctrl

// *** verif/nmi_host_model.sv ***
/*
  Model of the external host that borrows the narrow memory bus.
  Assumes the bench states its wish to own the bus on want, sampled at clk.
*/
module nmi_host_model (
  // Clock.
  input  wire logic clk,
  // Wish from the bench and grant from the block.
  input  wire logic want,
  input  wire logic ack_n,
  // Request to the block and bus ownership.
  output logic      hold_req,
  output logic      owns
);
  // Requests track the wish; ownership only once the grant is seen.
  always_ff @(posedge clk)
  begin
    hold_req <= want;
    owns     <= want & ~ack_n;
  end
endmodule : nmi_host_model

// *** verif/nmi_pin_ctrl_asserts.sv ***
/*
  Checker for the narrow memory pin control block.
  Assumes it is bound to the block and sees only the block's ports.
*/
module nmi_pin_ctrl_asserts (
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst_n,
  // Inputs watched.
  input wire logic               bus_hold_request,
  input wire nmi_pkg::nmi_mem_t  space_mem_type [4],
  input wire logic               read_enable_select,
  input wire logic               mem_is_8bit,
  input wire nmi_pkg::nmi_acc_t  acc,
  // Outputs watched.
  input wire logic               acc_ready,
  input wire nmi_pkg::nmi_pins_t pins,
  input wire logic               pins_oe,
  input wire logic               bus_grant_ack_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A beat taken, and one that falls in the external space window.
  sequence beat_s;
    acc.valid && acc_ready;
  endsequence
  sequence hit_s;
    beat_s ##0 acc.word_addr[31:28] == 4'h8;
  endsequence

  one_select_a:
    assert property ($onehot0(~pins.space_select_n)) else $error("two space selects");
  hit_select_a:
    assert property (hit_s |=> pins.space_select_n == ~(4'h1 << $past(acc.word_addr[27:26])))
    else $error("wrong space select");
  miss_select_a:
    assert property (beat_s ##0 acc.word_addr[31:28] != 4'h8 |=> &pins.space_select_n)
    else $error("select outside space");
  lane_narrow_a:
    assert property (beat_s ##0 mem_is_8bit |=> pins.byte_lane_select_n == 2'b10)
    else $error("narrow lane wrong");
  sync_addr_a:
    assert property (hit_s ##0 space_mem_type[acc.word_addr[27:26]] == nmi_pkg::MEM_SYNC
      && !read_enable_select && acc.stb.addr_stb |=> !pins.read_strobe_n)
    else $error("address strobe missing");
  grant_float_a:
    assert property (!bus_grant_ack_n |-> !pins_oe && !acc_ready) else $error("driving in grant");
  grant_bound_a:
    assert property ($rose(bus_hold_request) ##0 (bus_hold_request && !acc.valid)[*4]
      |-> ##[0:2] !bus_grant_ack_n) else $error("grant late");
  release_a:
    assert property ($fell(bus_hold_request) ##0 !bus_grant_ack_n
      |-> ##[1:5] (bus_grant_ack_n && pins_oe)) else $error("release late");
endmodule : nmi_pin_ctrl_asserts

bind nmi_pin_ctrl nmi_pin_ctrl_asserts u_nmi_pin_ctrl_asserts (.clk, .rst_n,
  .bus_hold_request, .space_mem_type, .read_enable_select, .mem_is_8bit, .acc,
  .acc_ready, .pins, .pins_oe, .bus_grant_ack_n);

// *** verif/tb_narrow_ext_memory_pin_control.sv ***
/*
  Self-checking bench for the narrow memory pin control block.
  Assumes the package, the checker and the host model are compiled first.
*/
module tb_narrow_ext_memory_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst_n, hold, want, owns, res, m8, rdy, oe, ack_n, need;
  logic                iclk = 1'b0;
  logic [1:0]          strap;
  nmi_pkg::nmi_mem_t   mt [4];
  nmi_pkg::nmi_ratio_t ratio;
  nmi_pkg::nmi_acc_t   acc;
  nmi_pkg::nmi_pins_t  pins;
  nmi_pkg::nmi_src_t   src;
  int                  mismatches, samples_checked, hp;
  int                  tick = 0;

  nmi_pin_ctrl u_nmi_pin_ctrl (.clk(clk), .rst_n(rst_n), .iface_clock_in(iclk),
    .iface_address_strap(strap), .bus_hold_request(hold), .space_mem_type(mt),
    .read_enable_select(res), .mem_is_8bit(m8), .clk_ratio(ratio), .acc(acc),
    .acc_ready(rdy), .pins(pins), .pins_oe(oe), .bus_grant_ack_n(ack_n),
    .bus_need_request(need), .clk_source(src));
  nmi_host_model u_nmi_host_model (.clk(clk), .want(want), .ack_n(ack_n),
    .hold_req(hold), .owns(owns));

  // Core clock, and an interface clock pin that flips every fifth cycle.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    tick <= (tick == 4) ? 0 : tick + 1;
    if (tick == 4) iclk <= ~iclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Reset with a strap and a divide ratio held on the pins.
  task automatic do_reset(input logic [1:0] s, input nmi_pkg::nmi_ratio_t r);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    ratio <= r;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset

  // One beat, then compare selects, lanes and the three strobes.
  task automatic beat(input logic [31:0] a, input logic [6:0] s, input logic [3:0] f,
                      input logic [9:0] exp);
    @(posedge clk);
    acc <= '{1'b1, f[3], f[2], f[1], f[0], a, s};
    @(posedge clk);
    acc.valid <= 1'b0;
    #1;
    chk({pins.space_select_n, pins.byte_lane_select_n, pins.read_strobe_n,
         pins.output_strobe_n, pins.write_strobe_n, pins.peripheral_direct_transfer_n},
        {6'h0, exp});
  endtask : beat

  // Cycles between two changes of one output clock.
  task automatic half_period(input logic div, output int n);
    logic last, now;
    int   k, start;
    // Let the edge that returned the caller settle before taking the first level.
    #1;
    start = -1;
    n     = 0;
    last  = div ? pins.divided_clock_out : pins.full_rate_clock_out;
    for (k = 0; k < 200 && n == 0; k++)
    begin
      @(posedge clk);
      #1;
      now = div ? pins.divided_clock_out : pins.full_rate_clock_out;
      if (now !== last && start >= 0) n = k - start;
      if (now !== last) start = k;
      last = now;
    end
  endtask : half_period

  // Source strap and both output clocks for one strap and ratio.
  task automatic test_clock(input logic [1:0] s, input nmi_pkg::nmi_src_t e, input int h,
                            input nmi_pkg::nmi_ratio_t r, input int m);
    do_reset(s, r);
    chk(16'(src), 16'(e));
    half_period(1'b0, hp);
    chk(16'(hp), 16'(h));
    half_period(1'b1, hp);
    chk(16'(hp), 16'(h * m));
  endtask : test_clock

  // Host borrows the bus, then hands it back.
  task automatic test_hold;
    @(posedge clk);
    want <= 1'b1;
    for (int k = 0; k < 20 && ack_n !== 1'b0; k++) @(posedge clk);
    acc.valid <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({ack_n, oe, rdy, need, owns}, 5'b00011);
    @(posedge clk);
    acc.valid <= 1'b0;
    want      <= 1'b0;
    for (int k = 0; k < 20 && ack_n !== 1'b1; k++) @(posedge clk);
    #1;
    chk({ack_n, oe, rdy}, 3'b111);
  endtask : test_hold

  initial
  begin
    {rst_n, want, res, m8} = '0;
    acc = '0;
    mt  = '{default: nmi_pkg::MEM_ASYNC};
    test_clock(2'h0, nmi_pkg::SRC_PIN, 5, nmi_pkg::DIV_BY1, 1);
    test_clock(2'h1, nmi_pkg::SRC_DIV4, 2, nmi_pkg::DIV_BY2, 2);
    test_clock(2'h2, nmi_pkg::SRC_DIV6, 3, nmi_pkg::DIV_BY4, 4);
    for (int i = 0; i < 4; i++)
      beat(32'h8000_0000 | (i << 26), 7'h40, 4'h0, {~(4'h1 << i), 6'b000111});
    beat(32'h4000_0000, 7'h40, 4'h0, 10'h3c7);
    beat(32'h8000_0000, 7'h10, 4'h9, 10'h3ac);
    beat(32'h8000_0000, 7'h10, 4'ha, 10'h39d);
    beat(32'h8000_0000, 7'h10, 4'hc, 10'h38d);
    beat(32'h8000_0000, 7'h40, 4'h1, 10'h386);
    @(posedge clk);
    m8    <= 1'b1;
    mt[1] <= nmi_pkg::MEM_SDRAM;
    mt[2] <= nmi_pkg::MEM_SYNC;
    beat(32'h8000_0000, 7'h40, 4'h0, 10'h3a7);
    beat(32'h8400_0000, 7'h07, 4'h0, 10'h361);
    beat(32'h8800_0000, 7'h28, 4'h0, 10'h2e3);
    @(posedge clk);
    res <= 1'b1;
    beat(32'h8800_0000, 7'h28, 4'h0, 10'h2eb);
    test_hold();
    wrap_up();
  end

  // Cut a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : tb_narrow_ext_memory_pin_control
